/* File: hw/usb_sie_pkg.sv */
// ***********************************************
// constants shared by the engine, its checks and its testbench
// ***********************************************
package usb_sie_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_TABLE_BASE = 8'h10;
  localparam logic [7:0] REG_START = 8'h14;
  localparam logic [7:0] REG_FRAME = 8'h18;
  // control register reset value
  localparam logic [3:0] CTRL_RST = 4'h0;
  // interrupt bit positions
  localparam int INT_ATTACH = 0;
  localparam int INT_DETACH = 1;
  localparam int INT_SOF = 2;
  localparam int INT_TICK = 3;
  localparam int INT_DONE = 4;
  localparam int INT_W = 5;
  // start register fields
  localparam int START_DIR = 4;
  localparam int START_EP_W = 4;
  // descriptor layout: word0 {own, count}, word1 buffer byte address
  localparam int DESC_OWN = 31;
  localparam int CNT_W = 10;
  localparam logic [31:0] DESC_WORD1 = 32'h0000_0004;
  localparam int TABLE_ALIGN = 9;
  // token bytes
  localparam logic [7:0] PID_SOF = 8'hA5;
  localparam int FRAME_W = 11;
  // timing: 1 ms frame at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int FRAME_US = 1000;
  localparam int FRAME_CYC = FRAME_US * CLK_MHZ;

  typedef struct packed {
    logic pingpong;
    logic frame_en;
    logic low_speed;
    logic host;
  } ctrl_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic we;
    logic req;
  } ram_req_s;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_DESC0 = 7'h02,
    S_DESC1 = 7'h04,
    S_TX = 7'h08,
    S_RX = 7'h10,
    S_WBACK = 7'h20,
    S_SOF = 7'h40
  } dma_state_e;
endpackage : usb_sie_pkg

/* File: hw/ms_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// enable-gated period divider, one-cycle tick
// ***********************************************
module ms_tick #(
  parameter int unsigned CYCLES = 250000
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic en,
  // tick out
  output logic tick_q
);
  logic [31:0] cnt_q;

  // counter restarts whenever disabled, so the first tick lands a full period after enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (!en) begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end
endmodule : ms_tick
`default_nettype wire

/* File: hw/usb_sie_dma.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - host or device role, chosen by software
// - low or full speed only
// - dedicated dma moves payload to and from ram
// - descriptor table base is 512-byte aligned
// - buffers may start at any byte address
// - ownership flag gates every buffer access
// - many maskable sources, one interrupt line
// - ping-pong gives two alternating buffers each
// - full-speed host sends sof every ms
// - low-speed host sends keep-alives every ms
// - free 1 ms timer interrupt always available
// - sof interrupt only when attached and enabled
// - attach and detach are level interrupts
// - speed sampled from idle line polarity
module usb_sie_dma
  import usb_sie_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // ram master
  output usb_sie_pkg::ram_req_s ram_q,
  input wire logic ram_ack,
  input wire logic [31:0] ram_rdata,
  // byte stream to the serializer
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic keepalive,
  // byte stream from the deserializer
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  // bus line levels, asynchronous
  input wire logic line_dp,
  input wire logic line_dm
);
  import usb_sie_pkg::*;

  ctrl_s ctrl_q;
  logic [INT_W-1:0] int_stat_q, int_mask_q, int_ev;
  logic [31:TABLE_ALIGN] table_base_q;
  logic [START_EP_W-1:0] ep_q;
  logic dir_q, start_q, done_q, sof_ev_q, ka_q;
  logic [31:0] pp_q;
  logic [FRAME_W-1:0] frame_q;
  dma_state_e state_q;
  logic [31:0] buf_q, rd_mux;
  logic [CNT_W-1:0] cnt_q, idx_q;
  logic [1:0] sof_idx_q;
  logic sof_pend_q, last_q, speed_full_q, tx_valid_q, rx_ready_q;
  logic [7:0] tx_data_q;
  logic dp_s1, dp_s2, dm_s1, dm_s2;
  logic frame_tick, otg_tick, attached, pp_sel, apb_acc;
  logic [31:0] desc_addr, byte_addr;
  logic [7:0] byte_rd;

  // ***********************************************
  // line synchroniser and line state
  // ***********************************************
  // two flops before any logic looks at the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_s1 <= 1'b0;
      dp_s2 <= 1'b0;
      dm_s1 <= 1'b0;
      dm_s2 <= 1'b0;
    end else begin
      dp_s1 <= line_dp;
      dp_s2 <= dp_s1;
      dm_s1 <= line_dm;
      dm_s2 <= dm_s1;
    end
  end

  // single-ended zero means nobody pulls a line up
  assign attached = dp_s2 | dm_s2;

  // idle polarity differs per speed; only trusted while we are quiet, so data cannot fool it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_full_q <= 1'b1;
    end else if (attached && state_q == S_IDLE && !rx_valid && (dp_s2 ^ dm_s2)) begin
      speed_full_q <= dp_s2;
    end
  end

  // ***********************************************
  // frame and on-the-go timers
  // ***********************************************
  ms_tick #(.CYCLES(FRAME_CYCLES)) u_frame_tick (
    .clk(clk),
    .resetn(resetn),
    .en(ctrl_q.frame_en & ctrl_q.host),
    .tick_q(frame_tick)
  );

  // the 1 ms timer runs whenever the engine is out of reset, unrelated to frames
  ms_tick #(.CYCLES(FRAME_CYCLES)) u_otg_tick (
    .clk(clk),
    .resetn(resetn),
    .en(1'b1),
    .tick_q(otg_tick)
  );

  // frame marker choice follows the speed bit; firmware must drop frame_en after detach
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sof_pend_q <= 1'b0;
      ka_q <= 1'b0;
      sof_ev_q <= 1'b0;
      frame_q <= '0;
    end else begin
      ka_q <= frame_tick & ctrl_q.low_speed;
      sof_ev_q <= frame_tick & attached;
      if (frame_tick) begin
        frame_q <= frame_q + 11'h001;
      end
      if (frame_tick && !ctrl_q.low_speed) begin
        sof_pend_q <= 1'b1;
      end else if (state_q == S_SOF && sof_idx_q == 2'h2 && tx_valid_q && tx_ready) begin
        sof_pend_q <= 1'b0;
      end
    end
  end

  // ***********************************************
  // dma engine
  // ***********************************************
  // one table entry per endpoint, direction and ping-pong half
  assign pp_sel = ctrl_q.pingpong & pp_q[{ep_q, dir_q}];
  assign desc_addr = {table_base_q, ep_q, dir_q, pp_sel, 3'h0};
  assign byte_addr = buf_q + {22'h000000, idx_q};
  assign byte_rd = ram_rdata[{ram_q.addr[1:0], 3'h0} +: 8];

  // the only driver of ram, tx and rx handshakes; sof waits for a transfer to finish
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      ram_q <= '0;
      cnt_q <= '0;
      idx_q <= '0;
      buf_q <= 32'h0000_0000;
      last_q <= 1'b0;
      done_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      rx_ready_q <= 1'b0;
      sof_idx_q <= 2'h0;
      pp_q <= 32'h0000_0000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (sof_pend_q) begin
            state_q <= S_SOF;
            sof_idx_q <= 2'h0;
            tx_data_q <= PID_SOF;
            tx_valid_q <= 1'b1;
          end else if (start_q) begin
            ram_q <= '{addr: desc_addr, wdata: 32'h0000_0000, be: 4'hF, we: 1'b0, req: 1'b1};
            state_q <= S_DESC0;
          end
        end
        S_DESC0: begin
          if (ram_ack) begin
            if (!ram_rdata[DESC_OWN]) begin
              ram_q.req <= 1'b0;
              state_q <= S_IDLE;
            end else begin
              cnt_q <= ram_rdata[CNT_W-1:0];
              ram_q.addr <= desc_addr + DESC_WORD1;
              state_q <= S_DESC1;
            end
          end
        end
        S_DESC1: begin
          if (ram_ack) begin
            buf_q <= ram_rdata;
            idx_q <= '0;
            last_q <= 1'b0;
            ram_q.req <= 1'b0;
            if (cnt_q == '0) begin
              ram_q <= '{addr: desc_addr, wdata: 32'h0000_0000, be: 4'hF, we: 1'b1, req: 1'b1};
              state_q <= S_WBACK;
            end else if (dir_q) begin
              state_q <= S_TX;
            end else begin
              rx_ready_q <= 1'b1;
              state_q <= S_RX;
            end
          end
        end
        S_TX: begin
          // byte-wide fetches keep odd buffer starts trivial at the cost of bandwidth
          if (!ram_q.req && !tx_valid_q) begin
            ram_q <= '{addr: byte_addr, wdata: 32'h0000_0000, be: 4'h1 << byte_addr[1:0], we: 1'b0, req: 1'b1};
          end else if (ram_q.req && ram_ack) begin
            ram_q.req <= 1'b0;
            tx_data_q <= byte_rd;
            tx_valid_q <= 1'b1;
          end else if (tx_valid_q && tx_ready) begin
            tx_valid_q <= 1'b0;
            idx_q <= idx_q + 10'h001;
            if (idx_q + 10'h001 == cnt_q) begin
              ram_q <= '{addr: desc_addr, wdata: {22'h000000, idx_q + 10'h001}, be: 4'hF, we: 1'b1, req: 1'b1};
              state_q <= S_WBACK;
            end
          end
        end
        S_RX: begin
          if (rx_valid && rx_ready_q) begin
            rx_ready_q <= 1'b0;
            last_q <= rx_last;
            ram_q <= '{addr: byte_addr, wdata: {4{rx_data}}, be: 4'h1 << byte_addr[1:0], we: 1'b1, req: 1'b1};
          end else if (ram_q.req && ram_ack) begin
            idx_q <= idx_q + 10'h001;
            if (last_q || idx_q + 10'h001 == cnt_q) begin
              ram_q <= '{addr: desc_addr, wdata: {22'h000000, idx_q + 10'h001}, be: 4'hF, we: 1'b1, req: 1'b1};
              state_q <= S_WBACK;
            end else begin
              ram_q.req <= 1'b0;
              rx_ready_q <= 1'b1;
            end
          end
        end
        S_WBACK: begin
          // own bit left clear hands the buffer back to the cpu
          // count was fixed on entry, so an ack in the first cycle still writes it
          if (ram_ack) begin
            ram_q.req <= 1'b0;
            done_q <= 1'b1;
            pp_q[{ep_q, dir_q}] <= ~pp_q[{ep_q, dir_q}];
            state_q <= S_IDLE;
          end
        end
        S_SOF: begin
          if (tx_ready) begin
            sof_idx_q <= sof_idx_q + 2'h1;
            tx_data_q <= sof_idx_q == 2'h0 ? frame_q[7:0] : {5'h00, frame_q[10:8]};
            if (sof_idx_q == 2'h2) begin
              tx_valid_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // write-back word is built on the edge that enters S_WBACK; the ram may answer
  // at once, so nothing in the request may change while it waits

  // ***********************************************
  // apb register file
  // ***********************************************
  assign apb_acc = psel & penable & ~pready;

  // read mux; unmapped offsets read zero, and those above REG_FRAME flag an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rd_mux = {28'h0000000, ctrl_q};
      REG_STAT: rd_mux = {28'h0000000, pp_sel, state_q != S_IDLE, speed_full_q, attached};
      REG_INT_STAT: rd_mux = {27'h0000000, int_stat_q};
      REG_INT_MASK: rd_mux = {27'h0000000, int_mask_q};
      REG_TABLE_BASE: rd_mux = {table_base_q, 9'h000};
      REG_START: rd_mux = {27'h0000000, dir_q, ep_q};
      REG_FRAME: rd_mux = {21'h000000, frame_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state per access keeps every apb output on a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_acc;
      prdata <= apb_acc && !pwrite ? rd_mux : 32'h0000_0000;
      pslverr <= apb_acc && paddr > REG_FRAME;
    end
  end

  // software-owned configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
      int_mask_q <= '0;
      table_base_q <= '0;
      ep_q <= '0;
      dir_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      if (state_q == S_IDLE && !sof_pend_q) begin
        start_q <= 1'b0;
      end
      if (apb_acc && pwrite) begin
        case (paddr)
          REG_CTRL: ctrl_q <= pwdata[3:0];
          REG_INT_MASK: int_mask_q <= pwdata[INT_W-1:0];
          REG_TABLE_BASE: table_base_q <= pwdata[31:TABLE_ALIGN];
          REG_START: begin
            // a start while busy is ignored; software waits for ownership to return
            if (state_q == S_IDLE && !start_q) begin
              ep_q <= pwdata[START_EP_W-1:0];
              dir_q <= pwdata[START_DIR];
              start_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ***********************************************
  // interrupt status, mask and line
  // ***********************************************
  // attach and detach re-assert every cycle their line condition holds
  assign int_ev = {done_q, otg_tick, sof_ev_q, ~attached, attached};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      if (apb_acc && pwrite && paddr == REG_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~pwdata[INT_W-1:0]) | int_ev;
      end else begin
        int_stat_q <= int_stat_q | int_ev;
      end
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  // registered stream outputs
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign rx_ready = rx_ready_q;
  assign keepalive = ka_q;
endmodule : usb_sie_dma
`default_nettype wire

/* File: bench/usb_sie_dma_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks of the usb engine
// ****
module usb_sie_dma_props
  import usb_sie_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // ram and stream
  input wire usb_sie_pkg::ram_req_s ram_q,
  input wire logic ram_ack,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic keepalive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // an access phase not yet answered, then a one-cycle answer
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_answer; s_access |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("apb answer late or long");
  property p_err_hi; s_access ##0 paddr > REG_FRAME |=> pslverr && prdata == 32'h0; endproperty
  a_err_hi: assert property (p_err_hi) else $error("unmapped access not refused");
  property p_err_lo; s_access ##0 paddr <= REG_FRAME |=> !pslverr; endproperty
  a_err_lo: assert property (p_err_lo) else $error("mapped access refused");
  property p_idle_data; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
  // a held request must not drift while the ram is slow
  property p_ram_hold; ram_q.req && !ram_ack |=> ram_q.req && $stable(ram_q.addr) && $stable(ram_q.we)
    && $stable(ram_q.wdata); endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("ram request dropped");
  property p_lane; ram_q.req && ram_q.we && ram_q.be != 4'hF |-> ram_q.be == 4'h1 << ram_q.addr[1:0]; endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_ka; keepalive |=> !keepalive ##1 !keepalive; endproperty
  a_ka: assert property (p_ka) else $error("keepalive not a pulse");
endmodule : usb_sie_dma_props
bind usb_sie_dma usb_sie_dma_props #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ram_q(ram_q), .ram_ack(ram_ack), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .keepalive(keepalive));
`default_nettype wire

/* File: bench/usb_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// peripheral on the far side of the link
// ****
module usb_far_end (
  // clock and stimulus
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic stall,
  // byte streams
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  // bus lines
  output logic line_dp,
  output logic line_dm
);
  logic [7:0] got[$];
  logic [7:0] rxq[$];
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = 8'h00;
  end
  // idle polarity marks the speed; detached leaves both lines pulled low
  assign line_dp = mode == 2'h1;
  assign line_dm = mode == 2'h2;
  // sink with random stalls; source holds each byte until taken
  always @(posedge clk) begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (rx_valid && rx_ready) void'(rxq.pop_front());
    if (rxq.size() != 0) begin
      rx_valid <= 1'b1;
      rx_data <= rxq[0];
      rx_last <= rxq.size() == 1;
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data; // released lines must not look valid
      rx_last <= 1'b0;
    end
  end
endmodule : usb_far_end
`default_nettype wire

/* File: bench/usb_sie_dma_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_sie_dma_tb;
  import usb_sie_pkg::*;
  localparam int unsigned FC = 50;
  localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, tx_valid, tx_ready, keepalive, rx_valid, rx_last, rx_ready, line_dp, line_dm;
  logic [7:0] tx_data, rx_data;
  ram_req_s ram_q;
  logic ram_ack = 1'b0;
  logic [31:0] ram_rdata = 32'h0;
  logic [1:0] mode = 2'h0;
  logic stall = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [31:0] seed = 32'h8AB0;
  logic [7:0] mem [0:8191];
  logic [7:0] rxb [3];
  logic [7:0] regs [5] = '{REG_CTRL, REG_INT_MASK, REG_TABLE_BASE, REG_FRAME, 8'h1C};
  logic [32:0] eq[$], mq[$];
  int n_mismatch = 0;
  int comparisons = 0;
  wire logic [12:0] ra = {ram_q.addr[12:2], 2'b00};
  usb_sie_dma #(.FRAME_CYCLES(FC)) DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .ram_q(ram_q), .ram_ack(ram_ack), .ram_rdata(ram_rdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .keepalive(keepalive), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .line_dp(line_dp), .line_dm(line_dm));
  usb_far_end u_far (.clk(clk), .mode(mode), .stall(stall), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
    .line_dp(line_dp), .line_dm(line_dm));
  always #2 clk = ~clk;
  // ****
  // helpers
  // ****
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function logic [31:0] getw(input logic [12:0] a);
    return {mem[a + 13'h3], mem[a + 13'h2], mem[a + 13'h1], mem[a]};
  endfunction : getw
  task setw(input logic [12:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) mem[a + 13'(i)] = w[8 * i +: 8];
  endtask : setw
  task chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task stop_test;
    $display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // one apb transfer; a read leaves its expectation for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 1, 0);
      stop_test();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr
  // bounded wait: 0 irq, 1 three bytes sent, 2 keepalive
  task waitk(input int lim, input int sel);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!(sel == 0 ? irq === 1'b1 : sel == 1 ? u_far.got.size() >= 3 : keepalive === 1'b1) && k < lim);
    if (k >= lim) begin
      chk("wait", 1, 0);
      stop_test();
    end
  endtask : waitk
  // ****
  // ram with random latency, and the read monitor
  // ****
  always @(posedge clk) begin
    ram_ack <= 1'b0;
    ram_rdata <= ~ram_rdata;
    stall <= xs() > 32'h9000_0000;
    if (ram_q.req && !ram_ack) begin
      if (lat != 2'h0) lat <= lat - 2'h1;
      else begin
        ram_ack <= 1'b1;
        lat <= 2'(xs());
        ram_rdata <= getw(ra);
        if (ram_q.we) for (int i = 0; i < 4; i++) if (ram_q.be[i]) mem[ra + 13'(i)] <= ram_q.wdata[8 * i +: 8];
      end
    end
  end
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("apb read", eq[0] & mq[0], {pslverr, prdata} & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    chk("run time", 0, 1);
    stop_test();
  end
  // ****
  // main sequence
  // ****
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'(xs());
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    foreach (regs[i]) apb(1'b0, regs[i], 0, {regs[i] == 8'h1C, 32'h0}, ALL);
    $display("test reset done");
    wr(REG_CTRL, 32'h5);
    wr(REG_INT_MASK, 32'h8);
    wr(REG_INT_STAT, 32'h1F);
    waitk(FC + 20, 0);
    apb(1'b0, REG_INT_STAT, 0, 33'hA, 33'hE);
    wr(REG_INT_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", 0, irq);
    wr(REG_CTRL, 32'h0);
    mode <= 2'h1;
    repeat (20) @(posedge clk);
    u_far.got.delete();
    wr(REG_INT_STAT, 32'h1F);
    apb(1'b0, REG_STAT, 0, 33'h3, 33'h3);
    apb(1'b0, REG_INT_STAT, 0, 33'h1, 33'h3);
    $display("test tick and attach done");
    wr(REG_CTRL, 32'h5);
    wr(REG_INT_STAT, 32'h1F);
    waitk(FC + 200, 1);
    chk("sof pid", PID_SOF, u_far.got[0]);
    chk("frame top", 0, u_far.got[2][7:3]);
    apb(1'b0, REG_INT_STAT, 0, 33'h4, 33'h4);
    mode <= 2'h2;
    wr(REG_CTRL, 32'h7);
    repeat (20) @(posedge clk);
    u_far.got.delete();
    apb(1'b0, REG_STAT, 0, 33'h1, 33'h3);
    waitk(FC + 20, 2);
    chk("bytes in low speed", 0, 33'(u_far.got.size()));
    wr(REG_CTRL, 32'h0);
    mode <= 2'h1;
    $display("test frames done");
    wr(REG_TABLE_BASE, 32'h2FF);
    apb(1'b0, REG_TABLE_BASE, 0, 33'h200, ALL);
    setw(13'h230, 32'h8000_0003);
    setw(13'h234, 32'h1001);
    wr(REG_INT_MASK, 32'h10);
    wr(REG_INT_STAT, 32'h1F);
    wr(REG_START, 32'h11);
    waitk(300, 0);
    for (int i = 0; i < 3; i++) chk("tx byte", mem[13'h1001 + 13'(i)], u_far.got[i]);
    chk("tx write back", 33'h3, getw(13'h230));
    setw(13'h240, 32'h8000_0008);
    setw(13'h244, 32'h1103);
    foreach (rxb[i]) begin
      rxb[i] = 8'(xs());
      u_far.rxq.push_back(rxb[i]);
    end
    wr(REG_INT_STAT, 32'h1F);
    wr(REG_START, 32'h02);
    waitk(300, 0);
    foreach (rxb[i]) chk("rx byte", rxb[i], mem[13'h1103 + 13'(i)]);
    chk("rx write back", 33'h3, getw(13'h240));
    wr(REG_INT_STAT, 32'h1F);
    wr(REG_START, 32'h11);
    repeat (40) @(posedge clk);
    apb(1'b0, REG_INT_STAT, 0, 33'h0, 33'h10);
    chk("bytes without ownership", 3, 33'(u_far.got.size()));
    $display("test dma done");
    wr(REG_CTRL, 32'h8);
    setw(13'h230, 32'h8000_0001);
    setw(13'h238, 32'h8000_0002);
    setw(13'h23C, 32'h1010);
    for (int i = 0; i < 2; i++) begin
      wr(REG_INT_STAT, 32'h1F);
      wr(REG_START, 32'h11);
      waitk(300, 0);
    end
    chk("second half count", 33'h2, getw(13'h238));
    chk("ping-pong bytes", 6, 33'(u_far.got.size()));
    mode <= 2'h0;
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    wr(REG_INT_STAT, 32'h1F);
    apb(1'b0, REG_INT_STAT, 0, 33'h2, 33'h3);
    $display("test ping-pong and detach done");
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule : usb_sie_dma_tb
`default_nettype wire
